// *** ladder_ref_regs.svh ***
`ifndef LADDER_REF_REGS_SVH
`define LADDER_REF_REGS_SVH

// Register byte addresses
`define REF_CONTROL_MAIN_ADDR   8'h00
`define REF_LEVEL_SELECT_ADDR   8'h04
`define SLEEP_STATUS_ADDR       8'h08

// ref_control_main fields
`define LADDER_ENABLE_BIT       7
`define LOW_POWER_END_BIT       6
`define REF_PIN_OE_BIT          5
`define POS_SRC_MSB             3
`define POS_SRC_LSB             2
`define CONTROL_MAIN_MASK       8'hec

// ref_level_select fields
`define LEVEL_CODE_MSB          4
`define LEVEL_CODE_LSB          0
`define LEVEL_SELECT_MASK       8'h1f

// Reset values
`define CONTROL_MAIN_RESET      8'h00
`define LEVEL_SELECT_RESET      8'h00

// Level code extremes
`define LEVEL_CODE_ALL_ONES     5'h1f
`define LEVEL_CODE_ALL_ZEROS    5'h00

// AXI responses
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// *** ladder_ref_pkg.sv ***
package ladder_ref_pkg;

    typedef enum logic [1:0] {
        SRC_SUPPLY    = 2'h0,
        SRC_EXT_PIN   = 2'h1,
        SRC_FIXED_BUF = 2'h2,
        SRC_RESERVED  = 2'h3
    } pos_source_e;

    typedef enum logic [2:0] {
        LADDER_OFF     = 3'h1,
        LADDER_ACTIVE  = 3'h2,
        LADDER_CLAMPED = 3'h4
    } ladder_mode_e;

endpackage

// *** ladder_axi_slave.sv ***
`timescale 1ns/1ns
`include "ladder_ref_regs.svh"

module ladder_axi_slave #(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output      logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output      logic                  s_axi_wready,
    output      logic [1:0]            s_axi_bresp,
    output      logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output      logic                  s_axi_arready,
    output      logic [31:0]           s_axi_rdata,
    output      logic [1:0]            s_axi_rresp,
    output      logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Register side
    output      logic                  wr_pulse,
    output      logic [ADDR_WIDTH-1:0] wr_addr,
    output      logic [7:0]            wr_data,
    output      logic [ADDR_WIDTH-1:0] rd_addr,
    input  wire logic [7:0]            rd_data,
    input  wire logic                  rd_hit,
    input  wire logic                  wr_hit
);

    initial begin
        if (ADDR_WIDTH < 4)
            $error("ADDR_WIDTH too small");
    end

    typedef struct packed {
        logic                  aw_full;
        logic [ADDR_WIDTH-1:0] aw_addr;
        logic                  w_full;
        logic [7:0]            w_data;
        logic                  w_lane0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } axi_state_s;

    axi_state_s st_reg;
    axi_state_s st_next;
    logic       do_write;

    // Write fires once both halves are held and no response is pending
    assign do_write      = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
    assign s_axi_awready = !st_reg.aw_full;
    assign s_axi_wready  = !st_reg.w_full;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign wr_pulse      = do_write && wr_hit && st_reg.w_lane0;
    assign wr_addr       = st_reg.aw_addr;
    assign wr_data       = st_reg.w_data;
    assign rd_addr       = s_axi_araddr;

    always_comb begin
        st_next = st_reg;
        if (s_axi_awvalid && !st_reg.aw_full) begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_full) begin
            st_next.w_full  = 1'b1;
            st_next.w_data  = s_axi_wdata[7:0];
            st_next.w_lane0 = s_axi_wstrb[0];
        end
        if (do_write) begin
            st_next.aw_full = 1'b0;
            st_next.w_full  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;
        if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;
        if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = {24'h000000, rd_data};
            st_next.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

endmodule

// *** ladder_tap_decode.sv ***
`timescale 1ns/1ns
`include "ladder_ref_regs.svh"

module ladder_tap_decode #(
    parameter int LEVELS = 32
) (
    // Registered control fields
    input  wire logic                      enable,
    input  wire logic                      low_power_end,
    input  wire logic [$clog2(LEVELS)-1:0] level_code,
    // Ladder controls
    output      logic [LEVELS-1:0]         tap_select,
    output      logic                      pos_end_connect,
    output      logic                      neg_end_connect,
    output      logic                      clamp_to_pos,
    output      logic                      clamp_to_neg
);

    initial begin
        if (LEVELS != 32)
            $error("Ladder is built with 32 taps");
    end

    localparam int CW = $clog2(LEVELS);

    // One-hot tap; tap k gives neg + (pos - neg) * k / 32
    for (genvar k = 0; k < LEVELS; k++) begin : g_tap
        assign tap_select[k] = enable && (level_code == CW'(k));
    end

    // Disabled ladder drops one end to save current
    assign neg_end_connect = enable || !low_power_end;
    assign pos_end_connect = enable || low_power_end;
    assign clamp_to_pos    = !enable && low_power_end && (level_code == `LEVEL_CODE_ALL_ONES);
    assign clamp_to_neg    = !enable && !low_power_end && (level_code == `LEVEL_CODE_ALL_ZEROS);

endmodule

// *** voltage_ladder_ref_control.sv ***
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "ladder_ref_regs.svh"

// Functional notes
// - The ladder offers 32 levels picked by a 5-bit level code in the second register.
// - Bit 7 of the first register enables the ladder when set and disables it when clear.
// - While enabled the chosen tap gives ground plus the source span times the code over 32.
// - Disabled with the low-power bit set and code all ones, the output clamps to the positive source.
// - Disabled with the low-power bit clear and code all zeros, the output clamps to ground.
// - Bit 6 picks which end is cut: set cuts the negative end, clear cuts the positive end.
// - Bit 5 routes the reference to the output pin and forces its digital driver and input off.
// - A digital read of the output pin returns zero while it carries the reference.
// - Bits 3-2 pick the positive source: supply, external pin, fixed buffer two; code 11 is reserved.
// - The level code occupies bits 4-0 of the second register.
// - Unimplemented bits read as zero in both registers.
// - Waking from sleep leaves the first register unchanged.
// - Any device reset disables the ladder, releases the pin and clears the level code.

module voltage_ladder_ref_control #(
    parameter int ADDR_WIDTH = 8,
    parameter int LEVELS     = 32
) (
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_WIDTH-1:0]     s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output      logic                      s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output      logic                      s_axi_wready,
    output      logic [1:0]                s_axi_bresp,
    output      logic                      s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_WIDTH-1:0]     s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output      logic                      s_axi_arready,
    output      logic [31:0]               s_axi_rdata,
    output      logic [1:0]                s_axi_rresp,
    output      logic                      s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Sleep status from power control
    input  wire logic                      sleep_active,
    // Output pin digital path
    input  wire logic                      pin_digital_in,
    input  wire logic                      port_drive_en,
    output      logic                      pin_read_value,
    output      logic                      pin_driver_oe_n,
    output      logic                      pin_input_enable,
    output      logic                      ref_output_pin_connect,
    // Ladder and source controls
    output      logic [LEVELS-1:0]         tap_select,
    output      logic                      pos_end_connect,
    output      logic                      neg_end_connect,
    output      logic                      clamp_to_pos,
    output      logic                      clamp_to_neg,
    output      logic [2:0]                pos_source_onehot,
    output      logic                      ladder_enable_out
);

    localparam int CW = $clog2(LEVELS);

    initial begin
        if (LEVELS != 32)
            $error("Level code is fixed at 5 bits");
    end

    typedef struct packed {
        logic [7:0]                  control_main;
        logic [7:0]                  level_select;
        logic                        ladder_enable;
        logic                        low_power_end_select;
        logic                        ref_pin_output_enable;
        ladder_ref_pkg::pos_source_e positive_source_select;
        logic [CW-1:0]               level_code;
        ladder_ref_pkg::ladder_mode_e mode;
        logic                        pin_sync1;
        logic                        pin_sync2;
        logic                        sleep_sync1;
        logic                        sleep_sync2;
        logic                        pin_read;
        logic                        source_fault;
    } ctrl_state_s;

    ctrl_state_s st_reg;
    ctrl_state_s st_next;

    logic                  wr_pulse;
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic [7:0]            wr_data;
    logic [ADDR_WIDTH-1:0] rd_addr;
    logic [7:0]            rd_data;
    logic                  rd_hit;
    logic                  wr_hit;

    function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
        is_mapped = (a == `REF_CONTROL_MAIN_ADDR) || (a == `REF_LEVEL_SELECT_ADDR) ||
                    (a == `SLEEP_STATUS_ADDR);
    endfunction

    assign wr_hit = (wr_addr == `REF_CONTROL_MAIN_ADDR) || (wr_addr == `REF_LEVEL_SELECT_ADDR);
    assign rd_hit = is_mapped(rd_addr);

    always_comb begin
        case (rd_addr)
            `REF_CONTROL_MAIN_ADDR:  rd_data = st_reg.control_main & `CONTROL_MAIN_MASK;
            `REF_LEVEL_SELECT_ADDR:  rd_data = st_reg.level_select & `LEVEL_SELECT_MASK;
            `SLEEP_STATUS_ADDR:      rd_data = {6'h00, st_reg.source_fault, st_reg.sleep_sync2};
            default:                 rd_data = 8'h00;
        endcase
    end

    ladder_axi_slave #(
        .ADDR_WIDTH (ADDR_WIDTH)
    ) u_axi (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_pulse      (wr_pulse),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_hit        (rd_hit),
        .wr_hit        (wr_hit)
    );

    always_comb begin
        st_next = st_reg;
        // Sleep entry and exit never touch the registers
        if (wr_pulse && wr_addr == `REF_CONTROL_MAIN_ADDR)
            st_next.control_main = wr_data & `CONTROL_MAIN_MASK;
        if (wr_pulse && wr_addr == `REF_LEVEL_SELECT_ADDR)
            st_next.level_select = wr_data & `LEVEL_SELECT_MASK;
        // Analog controls follow the registers one edge later
        st_next.ladder_enable          = st_reg.control_main[`LADDER_ENABLE_BIT];
        st_next.low_power_end_select   = st_reg.control_main[`LOW_POWER_END_BIT];
        st_next.ref_pin_output_enable  = st_reg.control_main[`REF_PIN_OE_BIT];
        st_next.positive_source_select =
            ladder_ref_pkg::pos_source_e'(st_reg.control_main[`POS_SRC_MSB:`POS_SRC_LSB]);
        st_next.level_code             = st_reg.level_select[`LEVEL_CODE_MSB:`LEVEL_CODE_LSB];
        case (st_reg.mode)
            ladder_ref_pkg::LADDER_OFF,
            ladder_ref_pkg::LADDER_ACTIVE,
            ladder_ref_pkg::LADDER_CLAMPED: begin
                if (st_next.ladder_enable)
                    st_next.mode = ladder_ref_pkg::LADDER_ACTIVE;
                else if (clamp_next(st_next.low_power_end_select, st_next.level_code))
                    st_next.mode = ladder_ref_pkg::LADDER_CLAMPED;
                else
                    st_next.mode = ladder_ref_pkg::LADDER_OFF;
            end
            default: st_next.mode = ladder_ref_pkg::LADDER_OFF;
        endcase
        // Pin and sleep cross in through two flops
        st_next.pin_sync1   = pin_digital_in;
        st_next.pin_sync2   = st_reg.pin_sync1;
        st_next.sleep_sync1 = sleep_active;
        st_next.sleep_sync2 = st_reg.sleep_sync1;
        st_next.pin_read    = st_next.ref_pin_output_enable ? 1'b0 : st_reg.pin_sync2;
        // Sticky flag for the reserved source code; set wins, cleared by rewrite
        st_next.source_fault = (st_reg.source_fault &&
            !(wr_pulse && wr_addr == `REF_CONTROL_MAIN_ADDR)) ||
            (st_next.control_main[`POS_SRC_MSB:`POS_SRC_LSB] == 2'h3);
    end

    function automatic logic clamp_next(input logic lp, input logic [CW-1:0] code);
        clamp_next = (lp && code == `LEVEL_CODE_ALL_ONES) || (!lp && code == `LEVEL_CODE_ALL_ZEROS);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg      <= '0;
            st_reg.mode <= ladder_ref_pkg::LADDER_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    ladder_tap_decode #(
        .LEVELS (LEVELS)
    ) u_tap (
        .enable          (st_reg.ladder_enable),
        .low_power_end   (st_reg.low_power_end_select),
        .level_code      (st_reg.level_code),
        .tap_select      (tap_select),
        .pos_end_connect (pos_end_connect),
        .neg_end_connect (neg_end_connect),
        .clamp_to_pos    (clamp_to_pos),
        .clamp_to_neg    (clamp_to_neg)
    );

    // Reserved source code selects nothing rather than a random path
    always_comb begin
        case (st_reg.positive_source_select)
            ladder_ref_pkg::SRC_SUPPLY:    pos_source_onehot = 3'h1;
            ladder_ref_pkg::SRC_EXT_PIN:   pos_source_onehot = 3'h2;
            ladder_ref_pkg::SRC_FIXED_BUF: pos_source_onehot = 3'h4;
            default:                       pos_source_onehot = 3'h0;
        endcase
    end

    assign ladder_enable_out      = st_reg.ladder_enable;
    assign ref_output_pin_connect = st_reg.ref_pin_output_enable;
    assign pin_driver_oe_n        = !(port_drive_en && !st_reg.ref_pin_output_enable);
    assign pin_input_enable       = !st_reg.ref_pin_output_enable;
    assign pin_read_value         = st_reg.pin_read;

    // Checks
    property p_enable_follows;
        @(posedge aclk) disable iff (!aresetn)
        (wr_pulse && wr_addr == `REF_CONTROL_MAIN_ADDR) |-> ##2 (ladder_enable_out == $past(wr_data[7], 2));
    endproperty
    a_enable_follows: assert property (p_enable_follows) else $error("Enable did not follow write");

    property p_pin_reads_zero;
        @(posedge aclk) disable iff (!aresetn)
        (ref_output_pin_connect && $past(ref_output_pin_connect)) |-> !pin_read_value;
    endproperty
    a_pin_reads_zero: assert property (p_pin_reads_zero) else $error("Pin read not zero");

    property p_pin_override;
        @(posedge aclk) disable iff (!aresetn)
        ref_output_pin_connect |-> (pin_driver_oe_n && !pin_input_enable);
    endproperty
    a_pin_override: assert property (p_pin_override) else $error("Pin buffers not overridden");

    property p_single_tap;
        @(posedge aclk) disable iff (!aresetn)
        ladder_enable_out |-> ($onehot(tap_select) && tap_select[st_reg.level_code]);
    endproperty
    a_single_tap: assert property (p_single_tap) else $error("Tap select wrong");

    property p_clamp_pos;
        @(posedge aclk) disable iff (!aresetn)
        (!ladder_enable_out && st_reg.low_power_end_select && st_reg.level_code == 5'h1f)
            |-> (clamp_to_pos && !neg_end_connect && tap_select == '0);
    endproperty
    a_clamp_pos: assert property (p_clamp_pos) else $error("No clamp to positive");

    property p_clamp_neg;
        @(posedge aclk) disable iff (!aresetn)
        (!ladder_enable_out && !st_reg.low_power_end_select && st_reg.level_code == 5'h00)
            |-> (clamp_to_neg && !pos_end_connect);
    endproperty
    a_clamp_neg: assert property (p_clamp_neg) else $error("No clamp to negative");

    property p_unimpl_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000 && st_reg.control_main[4] == 1'b0 &&
                          st_reg.control_main[1:0] == 2'h0 && st_reg.level_select[7:5] == 3'h0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented bit set");

    property p_sleep_keeps;
        @(posedge aclk) disable iff (!aresetn)
        (!wr_pulse && $changed(st_reg.sleep_sync2)) |-> $stable(st_reg.control_main);
    endproperty
    a_sleep_keeps: assert property (p_sleep_keeps) else $error("Sleep changed control");

    property p_reset_clears;
        @(posedge aclk) $rose(aresetn) |-> (!ladder_enable_out && !ref_output_pin_connect &&
                                             st_reg.level_code == 5'h00);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("Reset did not clear");

    property p_level_lag;
        @(posedge aclk) disable iff (!aresetn)
        (wr_pulse && wr_addr == `REF_LEVEL_SELECT_ADDR) |-> ##2 (st_reg.level_code == $past(wr_data[4:0], 2));
    endproperty
    a_level_lag: assert property (p_level_lag) else $error("Level code lag wrong");

    property p_source_onehot;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.positive_source_select != ladder_ref_pkg::SRC_RESERVED) |-> $onehot(pos_source_onehot);
    endproperty
    a_source_onehot: assert property (p_source_onehot) else $error("Source select not one-hot");

    property p_pin_lag;
        @(posedge aclk) disable iff (!aresetn)
        (wr_pulse && wr_addr == `REF_CONTROL_MAIN_ADDR) |-> ##2 (ref_output_pin_connect == $past(wr_data[5], 2));
    endproperty
    a_pin_lag: assert property (p_pin_lag) else $error("Pin connect lag wrong");

    c_enable: cover property (@(posedge aclk) disable iff (!aresetn) $rose(ladder_enable_out));
    c_clamp_pos: cover property (@(posedge aclk) disable iff (!aresetn) clamp_to_pos);
    c_clamp_neg: cover property (@(posedge aclk) disable iff (!aresetn) clamp_to_neg && !ladder_enable_out);
    c_pin_out: cover property (@(posedge aclk) disable iff (!aresetn) ref_output_pin_connect);

endmodule

// *** ladder_pin_model.sv ***
`timescale 1ns/1ns
module ladder_pin_model #(
    parameter int LEVELS = 32
) (
    // Controls from the block, and the external pin level
    input  wire logic [LEVELS-1:0] tap_select,
    input  wire logic              clamp_to_pos,
    input  wire logic              clamp_to_neg,
    input  wire logic              ref_output_pin_connect,
    input  wire logic              ext_level,
    // Ladder output in steps, and pin level seen by the digital input
    output      logic [5:0]        out_level,
    output      logic              pin_digital_in
);
    always_comb begin
        out_level = 6'h00;
        for (int i = 0; i < LEVELS; i++) begin
            if (tap_select[i]) out_level = 6'(i);
        end
        if (clamp_to_pos) out_level = 6'(LEVELS);
        if (clamp_to_neg) out_level = 6'h00;
    end
    // Upper half of the ladder looks high on the pin, so the block must mask it
    assign pin_digital_in = ref_output_pin_connect ? (out_level >= 6'h10) : ext_level;
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleep_active;
    logic        port_drive_en, ext_level, pin_digital_in, pin_read_value, pin_driver_oe_n, pin_input_enable;
    logic        ref_output_pin_connect, pos_end_connect, neg_end_connect, clamp_to_pos, clamp_to_neg;
    logic        ladder_enable_out;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, tap_select;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  pos_source_onehot;
    logic [5:0]  out_level;
    int          fail_count, total_checks;
    int          codes[4] = '{0, 1, 17, 31};

    voltage_ladder_ref_control voltage_ladder_ref_control_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sleep_active, .pin_digital_in, .port_drive_en, .pin_read_value, .pin_driver_oe_n,
        .pin_input_enable, .ref_output_pin_connect, .tap_select, .pos_end_connect, .neg_end_connect,
        .clamp_to_pos, .clamp_to_neg, .pos_source_onehot, .ladder_enable_out);
    ladder_pin_model ladder_pin_model_inst (.tap_select, .clamp_to_pos, .clamp_to_neg, .ref_output_pin_connect,
        .ext_level, .out_level, .pin_digital_in);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // Bready raised with the request; it is only sampled once bvalid shows
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", 32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(name, s_axi_rdata, exp);
        check("rresp", 32'(s_axi_rresp), 32'(er));
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_active} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        port_drive_en = 1'b1;
        ext_level = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        rd("ctrl", 8'h00, 32'h0, 2'h0);
        rd("level", 8'h04, 32'h0, 2'h0);
        wr(8'h00, 8'hf7, 2'h0);
        tick(2);
        rd("ctrl", 8'h00, 32'he4, 2'h0);
        check("src", 32'(pos_source_onehot), 32'h2);
        wr(8'h04, 8'hff, 2'h0);
        rd("level", 8'h04, 32'h1f, 2'h0);
        for (int s = 0; s < 3; s++) begin
            wr(8'h00, 8'h80 | 8'(s << 2), 2'h0);
            tick(2);
            check("src", 32'(pos_source_onehot), 32'h1 << s);
            check("en", 32'(ladder_enable_out), 32'h1);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h04, 8'(codes[i]), 2'h0);
            tick(2);
            check("tap", tap_select, 32'h1 << codes[i]);
            check("vout", 32'(out_level), 32'(codes[i]));
            check("ends", 32'({pos_end_connect, neg_end_connect}), 32'h3);
        end
        wr(8'h00, 8'h40, 2'h0);
        tick(2);
        check("vout", 32'(out_level), 32'd32);
        check("ends", 32'({pos_end_connect, neg_end_connect}), 32'h2);
        wr(8'h04, 8'h00, 2'h0);
        wr(8'h00, 8'h00, 2'h0);
        tick(2);
        check("clamp_neg", 32'(clamp_to_neg), 32'h1);
        check("ends", 32'({pos_end_connect, neg_end_connect}), 32'h1);
        check("tap", tap_select, 32'h0);
        wr(8'h04, 8'h1f, 2'h0);
        wr(8'h00, 8'ha0, 2'h0);
        tick(5);
        check("pin_read", 32'(pin_read_value), 32'h0);
        check("pin_oe_n", 32'({pin_driver_oe_n, pin_input_enable}), 32'h2);
        wr(8'h00, 8'h84, 2'h0);
        tick(5);
        check("pin_read", 32'(pin_read_value), 32'h1);
        check("pin_oe_n", 32'({pin_driver_oe_n, pin_input_enable}), 32'h1);
        @(posedge aclk);
        port_drive_en <= 1'b0;
        tick(1);
        check("pin_oe_n", 32'({pin_driver_oe_n, pin_input_enable}), 32'h3);
        wr(8'h00, 8'h04, 2'h0);
        @(posedge aclk);
        sleep_active <= 1'b1;
        tick(5);
        rd("status", 8'h08, 32'h1, 2'h0);
        @(posedge aclk);
        sleep_active <= 1'b0;
        tick(5);
        rd("ctrl", 8'h00, 32'h04, 2'h0);
        wr(8'h08, 8'h55, 2'h2);
        rd("unmapped", 8'h0c, 32'h0, 2'h2);
        wr(8'h00, 8'ha4, 2'h0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        check("en", 32'({ladder_enable_out, ref_output_pin_connect}), 32'h0);
        rd("level", 8'h04, 32'h0, 2'h0);
        tally_and_finish();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
endmodule
